/* File: bench/wlan_link_status_supervisor_tb.sv */
// self-checking bench for the wireless link supervisor
module wlan_link_status_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import wlan_sup_pkg::*;
  logic          clk;
  logic          rst_b;
  logic          btn, hold5, confirm, op_on, joining, joined, failed, router_ok;
  menu_pick_t    pick;
  signal_level_t level;
  logic          fail_req, fail_err, sent, no_reply, err, valid;
  logic          ka, retry, erase, led, tled, lfault, rfault, disc;
  logic [7:0]    code;
  logic [1:0]    notes[$];
  int            n_mismatch, checks_done, ka_n, n, r, t;
  int unsigned   cyc;

  wlan_link_status_supervisor #(.MS_DIV(1)) u_wlan_link_status_supervisor (
    .CORE_CLK(clk), .RST_B(rst_b), .BTN_PRESS(btn), .BTN_HOLD_5S(hold5),
    .MENU_PICK(pick), .MENU_CONFIRM(confirm), .OPERATION_ON(op_on),
    .AP_JOINING(joining), .AP_JOINED(joined), .AP_FAILED(failed), .SIGNAL_LEVEL(level),
    .MSG_SENT(sent), .MSG_NO_REPLY(no_reply), .MSG_ERROR(err), .MSG_VALID(valid),
    .ROUTER_OK(router_ok), .KEEPALIVE_REQ(ka), .RETRY_REQ(retry), .ERASE_REQ(erase),
    .WLAN_LED(led), .TIMER_LED(tled), .LINK_FAULT(lfault), .FAULT_CODE(code),
    .ROUTER_FAULT(rfault), .WLAN_DISCONNECTED(disc));
  wlan_module_model u_wlan_module_model (
    .clk(clk), .keepalive_req(ka), .fail_req(fail_req), .fail_err(fail_err),
    .msg_sent(sent), .msg_no_reply(no_reply), .msg_error(err), .msg_valid(valid));

  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= rst_b ? cyc + 1 : 0;
  ////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic press();
    @(posedge clk);
    btn <= 1'b1;
    step(8);
    btn <= 1'b0;
    step(8);
  endtask
  task automatic wait_q(input int bound);
    for (int i = 0; i < bound && notes.size() != 0; i++) step(1);
    if (notes.size() != 0) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  // counts led changes and rising edges over k settled samples
  task automatic toggles(input int k, output int c, output int rs);
    logic prev;
    c = 0;
    rs = 0;
    @(negedge clk);
    prev = led;
    repeat (k) begin
      @(negedge clk);
      c += int'(led !== prev);
      rs += int'(led === 1'b1 && prev === 1'b0);
      prev = led;
    end
  endtask
  task automatic wait_rise(input int bound, output int tt);
    logic prev;
    tt = -1;
    @(negedge clk);
    prev = led;
    for (int i = 1; i <= bound && tt < 0; i++) begin
      @(negedge clk);
      if (led === 1'b1 && prev === 1'b0) tt = i;
      prev = led;
    end
  endtask
  ////////////////////////////////////////////////////////////
  // pulses are judged where they settle, half a cycle after the launching edge
  always @(negedge clk) begin
    if (rst_b === 1'b1 && ka === 1'b1) begin
      ka_n++;
      chk("keepalive time", 1, cyc >= 59990 && cyc <= 60010);
    end
    if (rst_b === 1'b1 && (retry === 1'b1 || erase === 1'b1)) begin
      if (notes.size() == 0) chk("pulse", 2'h0, {retry, erase});
      else chk("pulse", notes.pop_front(), {retry, erase});
    end
  end

  initial begin
    void'($urandom(13227));
    {btn, hold5, confirm, op_on, joining, joined, failed, fail_req, fail_err} = '0;
    pick = MENU_NONE;
    level = SIG_NONE;
    router_ok = 1'b1;
    rst_b = 1'b0;
    {n_mismatch, checks_done, ka_n} = '0;
    step(5);
    rst_b <= 1'b1;
    step(3);
    joined <= 1'b1;
    @(negedge clk);
    chk("led after reset", 0, led);
    chk("fault after reset", 0, lfault);
    press();
    @(negedge clk);
    chk("led on", 1, led);
    press();
    @(negedge clk);
    chk("led off", 0, led);
    press();
    joined <= 1'b0;
    joining <= 1'b1;
    step(10);
    toggles(2000, n, r);
    chk("fast blink", 1, n >= 15 && n <= 17);
    @(posedge clk);
    joining <= 1'b0;
    failed <= 1'b1;
    step(10);
    toggles(4000, n, r);
    chk("slow blink", 1, n >= 3 && n <= 5);
    @(posedge clk);
    failed <= 1'b0;
    joined <= 1'b1;
    step(10);
    toggles(2000, n, r);
    chk("steady", 0, n);
    chk("steady level", 1, led);
    // first failure only opens the check, the next three are retries
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      fail_err <= 1'($urandom_range(1));
      fail_req <= 1'b1;
      if (i > 0) notes.push_back(2'b10);
      step(1);
      fail_req <= 1'b0;
      step(6);
    end
    wait_q(50);
    @(negedge clk);
    chk("checking led", 1, led);
    chk("checking timer", 0, tled);
    chk("no early fault", 0, lfault);
    @(posedge clk);
    hold5 <= 1'b1;
    step(4);
    hold5 <= 1'b0;
    pick <= MENU_ERASE;
    confirm <= 1'b1;
    notes.push_back(2'b01);
    wait_q(5000);
    confirm <= 1'b0;
    pick <= MENU_NONE;
    @(negedge clk);
    chk("led after erase", 0, led);
    press();
    // strength confirm with operation running must be refused
    op_on <= 1'b1;
    router_ok <= 1'b0;
    hold5 <= 1'b1;
    step(4);
    hold5 <= 1'b0;
    pick <= MENU_STRENGTH;
    confirm <= 1'b1;
    step(4);
    confirm <= 1'b0;
    pick <= MENU_NONE;
    step(20);
    @(negedge clk);
    chk("strength refused", 1, led);
    press();
    @(negedge clk);
    chk("lit with op on", 1, led);
    @(posedge clk);
    op_on <= 1'b0;
    for (int lv = 3; lv >= 0; lv--) begin
      level <= signal_level_t'(lv);
      hold5 <= 1'b1;
      step(4);
      hold5 <= 1'b0;
      pick <= MENU_STRENGTH;
      confirm <= 1'b1;
      step(4);
      confirm <= 1'b0;
      pick <= MENU_NONE;
      wait_rise(9000, t);
      if (lv == 0) begin
        chk("no signal dark", 32'hFFFFFFFF, t);
      end else begin
        chk("strength delay", 1, t >= 4000);
        toggles(1500, n, r);
        chk("burst blinks", lv - 1, r);
      end
      press();
      step(10);
      toggles(4000, n, r);
      chk("display ended", 0, n);
      @(posedge clk);
    end
    while (cyc < 61000) step(1);
    @(negedge clk);
    chk("keepalive count", 1, ka_n);
    chk("router loss early", 0, rfault);
    chk("disconnect early", 0, disc);
    chk("fault code idle", 0, code);
    report_and_stop();
  end
endmodule

/* File: bench/wlan_module_model.sv */
// behavioural wireless module on the module link
module wlan_module_model #(
  parameter int REPLY_DLY = 3
) (
  input  wire logic clk,
  input  wire logic keepalive_req,
  input  wire logic fail_req,
  input  wire logic fail_err,
  output logic      msg_sent,
  output logic      msg_no_reply,
  output logic      msg_error,
  output logic      msg_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  int pend = 0;
  initial begin
    {msg_sent, msg_no_reply, msg_error, msg_valid} = 4'h0;
  end
  // failures only when the bench orders them; otherwise every keep-alive is answered
  always @(posedge clk) begin
    msg_sent     <= keepalive_req;
    msg_no_reply <= fail_req && !fail_err;
    msg_error    <= fail_req && fail_err;
    msg_valid    <= (pend == 1);
    pend         <= keepalive_req ? REPLY_DLY : (pend > 0 ? pend - 1 : 0);
  end
endmodule

/* File: bench/wlan_sup_asserts.sv */
// concurrent checks on the supervisor's top-level ports
module wlan_sup_asserts #(
  parameter int unsigned MS_DIV = 1
) (
  input wire logic       CORE_CLK,
  input wire logic       RST_B,
  input wire logic       MSG_NO_REPLY,
  input wire logic       MSG_ERROR,
  input wire logic       MSG_VALID,
  input wire logic       KEEPALIVE_REQ,
  input wire logic       RETRY_REQ,
  input wire logic       ERASE_REQ,
  input wire logic       WLAN_LED,
  input wire logic       TIMER_LED,
  input wire logic       LINK_FAULT,
  input wire logic [7:0] FAULT_CODE,
  input wire logic       ROUTER_FAULT
);
  timeunit 1ns;
  timeprecision 1ps;
  import wlan_sup_pkg::*;
  localparam int unsigned MIN_CYC = MS_DIV * MS_PER_SEC * MIN_SECONDS;
  int unsigned ka_cnt;
  logic [1:0]  retries;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_B);
  ////////////////////////////////////////////////////////////
  // retries saturate at three: only the threshold matters here
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ka_cnt  <= 0;
      retries <= 2'h0;
    end else begin
      ka_cnt <= KEEPALIVE_REQ ? 0 : ka_cnt + 1;
      if (MSG_VALID && !MSG_ERROR && !MSG_NO_REPLY) begin
        retries <= 2'h0;
      end else if (RETRY_REQ && retries != 2'h3) begin
        retries <= retries + 2'h1;
      end
    end
  end
  ////////////////////////////////////////////////////////////
  fault_code_a: assert property (
    FAULT_CODE == (LINK_FAULT ? MODULE_LINK_FAULT_CODE : 8'h00))
    else $error("fault code does not follow link fault");
  fault_led_a: assert property (
    LINK_FAULT && $past(LINK_FAULT) |-> !WLAN_LED)
    else $error("wireless led lit during confirmed fault");
  timer_dark_a: assert property (
    !LINK_FAULT && $past(!LINK_FAULT) |-> !TIMER_LED)
    else $error("timer led lit without link fault");
  fault_clear_a: assert property (
    LINK_FAULT && MSG_VALID && !MSG_ERROR && !MSG_NO_REPLY |=> !LINK_FAULT)
    else $error("valid module message did not clear fault");
  fault_cause_a: assert property (
    $rose(LINK_FAULT) |-> retries == 2'h3)
    else $error("fault confirmed before three retries");
  retry_cause_a: assert property (
    RETRY_REQ |-> $past(MSG_NO_REPLY || MSG_ERROR))
    else $error("retry without failed exchange");
  router_mask_a: assert property (
    ROUTER_FAULT |-> FAULT_CODE == 8'h00)
    else $error("router loss shows module link code");
  erase_off_a: assert property (
    ERASE_REQ |-> ##[0:1] !WLAN_LED)
    else $error("led not dark after erase");
  ka_pulse_a: assert property (
    KEEPALIVE_REQ |=> !KEEPALIVE_REQ [*8])
    else $error("keep-alive longer than one pulse");
  ka_gap_a: assert property (
    ka_cnt <= MIN_CYC + 4 && (!KEEPALIVE_REQ || ka_cnt >= MIN_CYC - 4))
    else $error("keep-alive spacing not one minute");
endmodule

bind wlan_link_status_supervisor wlan_sup_asserts #(.MS_DIV(MS_DIV)) u_wlan_sup_asserts (
  .CORE_CLK(CORE_CLK), .RST_B(RST_B), .MSG_NO_REPLY(MSG_NO_REPLY), .MSG_ERROR(MSG_ERROR),
  .MSG_VALID(MSG_VALID), .KEEPALIVE_REQ(KEEPALIVE_REQ), .RETRY_REQ(RETRY_REQ),
  .ERASE_REQ(ERASE_REQ), .WLAN_LED(WLAN_LED), .TIMER_LED(TIMER_LED),
  .LINK_FAULT(LINK_FAULT), .FAULT_CODE(FAULT_CODE), .ROUTER_FAULT(ROUTER_FAULT)
);

/* File: hdl/led_pattern.sv */
// wireless led pattern generator: fast, slow and strength bursts
module led_pattern (
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  tick_if.sink                             tk,
  input  wire logic                        fast,
  input  wire logic                        slow,
  input  wire logic                        burst,
  input  wire wlan_sup_pkg::signal_level_t level,
  output logic                             blink_fast,
  output logic                             blink_slow,
  output logic                             burst_led
);
  import wlan_sup_pkg::*;

  typedef struct packed {
    logic [11:0] fcnt;
    logic [11:0] scnt;
    logic [11:0] bcnt;
    logic [1:0]  blinks;
    logic        pause;
    logic        fled;
    logic        sled;
    logic        bled;
  } pat_state_t;

  pat_state_t st;
  pat_state_t next_st;

  always_comb begin
    next_st = st;
    if (!fast) begin
      next_st.fcnt = '0;
      next_st.fled = 1'b1;
    end else if (tk.ms_tick) begin
      if (st.fcnt == 12'(FAST_BLINK_MS - 1)) begin
        next_st.fcnt = '0;
        next_st.fled = ~st.fled;
      end else begin
        next_st.fcnt = st.fcnt + 12'h001;
      end
    end
    if (!slow) begin
      next_st.scnt = '0;
      next_st.sled = 1'b1;
    end else if (tk.ms_tick) begin
      if (st.scnt == 12'(SLOW_BLINK_MS - 1)) begin
        next_st.scnt = '0;
        next_st.sled = ~st.sled;
      end else begin
        next_st.scnt = st.scnt + 12'h001;
      end
    end
    // bursts of n blinks then a long pause; no signal keeps the led dark
    if (!burst || level == SIG_NONE) begin
      next_st.bcnt   = '0;
      next_st.blinks = '0;
      next_st.pause  = 1'b1;
      next_st.bled   = 1'b0;
    end else if (tk.ms_tick) begin
      next_st.bcnt = st.bcnt + 12'h001;
      if (st.pause) begin
        if (st.bcnt == 12'(BURST_PAUSE_MS - 1)) begin
          next_st.bcnt   = '0;
          next_st.pause  = 1'b0;
          next_st.bled   = 1'b1;
          next_st.blinks = 2'h0;
        end
      end else if (st.bcnt == 12'(BURST_ON_MS - 1)) begin
        next_st.bcnt = '0;
        if (st.bled) begin
          next_st.bled = 1'b0;
          next_st.blinks = st.blinks + 2'h1;
          if (st.blinks + 2'h1 == 2'(level)) begin
            next_st.pause = 1'b1;
          end
        end else begin
          next_st.bled = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '{default: '0, pause: 1'b1, fled: 1'b1, sled: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign blink_fast = st.fled;
  assign blink_slow = st.sled;
  assign burst_led  = st.bled;
endmodule

/* File: hdl/tick_gen.sv */
// common millisecond, second and minute tick generator
module tick_gen #(
  parameter int unsigned MS_DIV = wlan_sup_pkg::MS_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_b,
  tick_if.source    tk
);
  import wlan_sup_pkg::*;

  typedef struct packed {
    logic [31:0] div;
    logic [9:0]  ms;
    logic [5:0]  sec;
    logic        ms_p;
    logic        sec_p;
    logic        min_p;
  } tick_state_t;

  tick_state_t st;
  tick_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.ms_p  = 1'b0;
    next_st.sec_p = 1'b0;
    next_st.min_p = 1'b0;
    if (st.div == 32'(MS_DIV - 1)) begin
      next_st.div  = '0;
      next_st.ms_p = 1'b1;
      if (st.ms == 10'(MS_PER_SEC - 1)) begin
        next_st.ms    = '0;
        next_st.sec_p = 1'b1;
        if (st.sec == 6'(MIN_SECONDS - 1)) begin
          next_st.sec   = '0;
          next_st.min_p = 1'b1;
        end else begin
          next_st.sec = st.sec + 6'h01;
        end
      end else begin
        next_st.ms = st.ms + 10'h001;
      end
    end else begin
      next_st.div = st.div + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tk.ms_tick  = st.ms_p;
  assign tk.sec_tick = st.sec_p;
  assign tk.min_tick = st.min_p;
endmodule

/* File: hdl/tick_if.sv */
// millisecond, second and minute tick enables shared between supervisor modules
interface tick_if;
  logic sec_tick;
  logic min_tick;
  logic ms_tick;
  modport source (output sec_tick, output min_tick, output ms_tick);
  modport sink   (input  sec_tick, input  min_tick, input  ms_tick);
endinterface

/* File: hdl/wlan_link_status_supervisor.sv */
// wireless module supervisor: led sequences, keep-alive and fault tracking
module wlan_link_status_supervisor #(
  parameter int unsigned MS_DIV = wlan_sup_pkg::MS_CYCLES
) (
  input  wire logic                        CORE_CLK,
  input  wire logic                        RST_B,
  input  wire logic                        BTN_PRESS,
  input  wire logic                        BTN_HOLD_5S,
  input  wire wlan_sup_pkg::menu_pick_t    MENU_PICK,
  input  wire logic                        MENU_CONFIRM,
  input  wire logic                        OPERATION_ON,
  input  wire logic                        AP_JOINING,
  input  wire logic                        AP_JOINED,
  input  wire logic                        AP_FAILED,
  input  wire wlan_sup_pkg::signal_level_t SIGNAL_LEVEL,
  input  wire logic                        MSG_SENT,
  input  wire logic                        MSG_NO_REPLY,
  input  wire logic                        MSG_ERROR,
  input  wire logic                        MSG_VALID,
  input  wire logic                        ROUTER_OK,
  output logic                             KEEPALIVE_REQ,
  output logic                             RETRY_REQ,
  output logic                             ERASE_REQ,
  output logic                             WLAN_LED,
  output logic                             TIMER_LED,
  output logic                             LINK_FAULT,
  output logic [7:0]                       FAULT_CODE,
  output logic                             ROUTER_FAULT,
  output logic                             WLAN_DISCONNECTED
);
  import wlan_sup_pkg::*;

  typedef enum logic [2:0] {
    ST_OFF, ST_ON, ST_MENU, ST_ERASE_HOLD, ST_STR_WAIT, ST_STR_SHOW
  } mode_t;

  typedef struct packed {
    logic [1:0]  pin_s1;
    logic [1:0]  pin_s2;
    logic        press_q;
    mode_t       mode;
    logic [9:0]  sec_cnt;
    logic [3:0]  min_cnt;
    logic        checking;
    logic [3:0]  fault_min;
    logic [1:0]  retries;
    logic        fault;
    logic [8:0]  disc_sec;
    logic        disc;
    logic [2:0]  router_min;
    logic        router_retry;
    logic        router_fault;
    logic        keep;
    logic        retry;
    logic        erase;
    logic        wled;
    logic        tled;
    logic [9:0]  tblink;
  } sup_state_t;

  sup_state_t st;
  sup_state_t next_st;
  logic       press;
  logic       blink_fast;
  logic       blink_slow;
  logic       burst_led;

  // a failed exchange is either a missing reply or an error reply
  function automatic logic exch_failed(input logic no_reply, input logic err_reply);
    return no_reply | err_reply;
  endfunction

  // the led stays dark while the function is off or the strength wait runs
  function automatic logic led_dark(input mode_t m);
    return m == ST_OFF || m == ST_STR_WAIT;
  endfunction

  tick_if tk ();

  //////////////////////////////////////////////////////////////////////////////

  tick_gen #(.MS_DIV(MS_DIV)) u_ticks (
    .clk   (CORE_CLK),
    .rst_b (RST_B),
    .tk    (tk)
  );

  led_pattern u_pat (
    .clk        (CORE_CLK),
    .rst_b      (RST_B),
    .tk         (tk),
    .fast       (AP_JOINING),
    .slow       (AP_FAILED),
    .burst      (st.mode == ST_STR_SHOW),
    .level      (SIGNAL_LEVEL),
    .blink_fast (blink_fast),
    .blink_slow (blink_slow),
    .burst_led  (burst_led)
  );

  //////////////////////////////////////////////////////////////////////////////

  // only the remote-control button path comes from another domain
  // a held button acts once: only the synced rising edge counts
  assign press = st.pin_s2[0] & ~st.press_q;

  always_comb begin
    next_st = st;
    next_st.pin_s1 = {BTN_HOLD_5S, BTN_PRESS};
    next_st.pin_s2 = st.pin_s1;
    next_st.press_q = st.pin_s2[0];
    next_st.keep  = 1'b0;
    next_st.retry = 1'b0;
    next_st.erase = 1'b0;

    // button sequences; OPERATION_ON blocks only the strength check
    unique case (st.mode)
      ST_OFF: begin
        if (press) begin
          next_st.mode = ST_ON;
        end
      end
      ST_ON: begin
        if (st.pin_s2[1]) begin
          next_st.mode = ST_MENU;
        end else if (press) begin
          next_st.mode = ST_OFF;
        end
      end
      ST_MENU: begin
        next_st.sec_cnt = '0;
        if (MENU_CONFIRM && MENU_PICK == MENU_ERASE) begin
          next_st.mode = ST_ERASE_HOLD;
        end else if (MENU_CONFIRM && MENU_PICK == MENU_STRENGTH && !OPERATION_ON) begin
          next_st.mode = ST_STR_WAIT;
        end else if (press) begin
          next_st.mode = ST_ON;
        end
      end
      ST_ERASE_HOLD: begin
        // letting go of the item before the third second abandons the erase
        if (!MENU_CONFIRM) begin
          next_st.mode = ST_MENU;
        end else if (tk.sec_tick) begin
          next_st.sec_cnt = st.sec_cnt + 10'h001;
          if (st.sec_cnt == 10'(ERASE_HOLD_SEC - 1)) begin
            next_st.erase = 1'b1;
            next_st.mode  = ST_OFF;
          end
        end
      end
      ST_STR_WAIT: begin
        // whole seconds only: the first tick may come early, so 4 to 5 s
        if (press) begin
          next_st.mode = ST_ON;
        end else if (tk.sec_tick) begin
          next_st.sec_cnt = st.sec_cnt + 10'h001;
          if (st.sec_cnt == 10'(STRENGTH_DLY_SEC - 1)) begin
            next_st.sec_cnt = '0;
            next_st.mode    = ST_STR_SHOW;
          end
        end
      end
      ST_STR_SHOW: begin
        if (press) begin
          next_st.mode = ST_ON;
        end else if (tk.min_tick) begin
          next_st.sec_cnt = st.sec_cnt + 10'h001;
          if (st.sec_cnt == 10'(STRENGTH_MIN - 1)) begin
            next_st.mode = ST_ON;
          end
        end
      end
    endcase

    // keep-alive runs regardless of other traffic
    if (tk.min_tick) begin
      if (st.min_cnt == 4'(KEEPALIVE_MIN - 1)) begin
        next_st.min_cnt = '0;
        next_st.keep    = 1'b1;
      end else begin
        next_st.min_cnt = st.min_cnt + 4'h1;
      end
    end

    // module link fault: time and retry count both needed
    // the first failure only opens the check; up to three later ones are retries
    if (exch_failed(MSG_NO_REPLY, MSG_ERROR)) begin
      next_st.checking = 1'b1;
      if (st.checking && st.retries != 2'(LINK_RETRIES)) begin
        next_st.retries = st.retries + 2'h1;
      end
      if (st.checking && st.retries != 2'(LINK_RETRIES)) begin
        next_st.retry = 1'b1;
      end
    end
    if (st.checking && tk.min_tick && st.fault_min != 4'(LINK_FAULT_MIN)) begin
      next_st.fault_min = st.fault_min + 4'h1;
    end
    if (st.checking && st.fault_min == 4'(LINK_FAULT_MIN)
        && st.retries == 2'(LINK_RETRIES)) begin
      next_st.fault = 1'b1;
    end
    // a valid message loses to nothing but a same-cycle failed exchange (missing or error reply)
    if (MSG_VALID && !exch_failed(MSG_NO_REPLY, MSG_ERROR)) begin
      next_st.checking  = 1'b0;
      next_st.fault     = 1'b0;
      next_st.fault_min = '0;
      next_st.retries   = '0;
    end

    // wireless disconnection judgment
    if (MSG_VALID) begin
      next_st.disc_sec = '0;
      next_st.disc     = 1'b0;
    end else if (tk.sec_tick && st.disc_sec != 9'(DISCONNECT_SEC)) begin
      next_st.disc_sec = st.disc_sec + 9'h001;
    end
    if (st.disc_sec == 9'(DISCONNECT_SEC) && !MSG_VALID) begin
      next_st.disc = 1'b1;
    end

    // router loss: 5 minute ticks (4 to 5 minutes) and a retry made
    if (ROUTER_OK) begin
      next_st.router_min   = '0;
      next_st.router_retry = 1'b0;
      next_st.router_fault = 1'b0;
    end else begin
      if (MSG_SENT) begin
        next_st.router_retry = 1'b1;
      end
      if (tk.min_tick && st.router_min != 3'(ROUTER_LOSS_MIN)) begin
        next_st.router_min = st.router_min + 3'h1;
      end
      if (st.router_min == 3'(ROUTER_LOSS_MIN) && st.router_retry) begin
        next_st.router_fault = 1'b1;
      end
    end

    // timer led blink while fault stands
    // free-running: the blink phase is not aligned to fault entry
    if (tk.ms_tick) begin
      next_st.tblink = st.tblink + 10'h001;
    end
    next_st.tled = st.fault & st.tblink[9];

    // led priority: strength display, fault, router, ap status
    if (st.mode == ST_STR_SHOW) begin
      next_st.wled = burst_led;
    end else if (led_dark(st.mode)) begin
      next_st.wled = 1'b0;
    end else if (st.fault) begin
      next_st.wled = 1'b0;
    end else if (st.router_fault) begin
      next_st.wled = blink_slow;
    end else if (AP_JOINING) begin
      next_st.wled = blink_fast;
    end else if (AP_FAILED) begin
      next_st.wled = blink_slow;
    end else if (AP_JOINED) begin
      next_st.wled = 1'b1;
    end else begin
      next_st.wled = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st <= '{default: '0, mode: ST_OFF};
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  assign KEEPALIVE_REQ     = st.keep;
  assign RETRY_REQ         = st.retry;
  assign ERASE_REQ         = st.erase;
  assign WLAN_LED          = st.wled;
  assign TIMER_LED         = st.tled;
  assign LINK_FAULT        = st.fault;
  assign FAULT_CODE        = st.fault ? MODULE_LINK_FAULT_CODE : 8'h00;
  assign ROUTER_FAULT      = st.router_fault & ~st.fault;
  assign WLAN_DISCONNECTED = st.disc;
endmodule

/* File: hdl/wlan_sup_pkg.sv */
// shared constants and types for the wireless link supervisor
package wlan_sup_pkg;
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned SEC_CYCLES      = CLK_HZ;
  localparam int unsigned MIN_SECONDS     = 60;
  localparam int unsigned MS_PER_SEC      = 1000;
  localparam int unsigned HOLD_MENU_SEC   = 5;
  localparam int unsigned ERASE_HOLD_SEC  = 3;
  localparam int unsigned STRENGTH_DLY_SEC = 5;
  localparam int unsigned STRENGTH_MIN    = 10;
  localparam int unsigned KEEPALIVE_MIN   = 1;
  localparam int unsigned LINK_FAULT_MIN  = 10;
  localparam int unsigned LINK_RETRIES    = 3;
  localparam int unsigned DISCONNECT_SEC  = 300;
  localparam int unsigned ROUTER_LOSS_MIN = 5;
  localparam int unsigned FAST_BLINK_MS   = 125;
  localparam int unsigned SLOW_BLINK_MS   = 1000;
  localparam int unsigned BURST_ON_MS     = 250;
  localparam int unsigned BURST_PAUSE_MS  = 2000;
  localparam int unsigned MS_CYCLES       = CLK_HZ / 1000;
  localparam logic [7:0]  MODULE_LINK_FAULT_CODE = 8'h85;

  typedef enum logic [1:0] {
    SIG_NONE, SIG_WEAK, SIG_MODERATE, SIG_STRONG
  } signal_level_t;

  typedef enum logic [1:0] {
    MENU_NONE, MENU_STRENGTH, MENU_ERASE
  } menu_pick_t;
endpackage
